// ### hw/eesm_pkg.sv
// What this block does
// - pins appear only when enable bit set
// - byte register 0x9e, command/status 0x9f
// - bit 6 high while bus operation runs
// - busy falling edge pulses the interrupt
// - bit 5 shows memory acknowledged last byte
// - bit 4 shows controller sent acknowledge
// - code 2 receives byte, sends acknowledge
// - code 6 receives last byte, no acknowledge
// - received byte lands in byte register
// - code 5 issues stop sequence
// - code 9 issues start sequence
// - code 0 halts free running clock
// - code 3 sends byte; other codes do nothing, set error bit
// - clock 78kHz in transfer and while free running, else high
// - sole master, no stretching or arbitration
package eesm_pkg;
   // register map on the special-function port
   localparam logic [7:0] SFR_BYTE_ADDR = 8'h9e;
   localparam logic [7:0] SFR_CMD_ADDR = 8'h9f;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // configuration location holding the pin enable
   localparam logic [15:0] CFG_PIN_ADDR = 16'h2008;
   localparam int CFG_PIN_BIT = 4;
   // status field positions
   localparam int ST_ERROR = 7;
   localparam int ST_BUSY = 6;
   localparam int ST_RX_ACK = 5;
   localparam int ST_TX_ACK = 4;
   // command codes
   localparam logic [3:0] CMD_NOOP = 4'h0;
   localparam logic [3:0] CMD_RX_ACK = 4'h2;
   localparam logic [3:0] CMD_TX = 4'h3;
   localparam logic [3:0] CMD_STOP = 4'h5;
   localparam logic [3:0] CMD_RX_LAST = 4'h6;
   localparam logic [3:0] CMD_START = 4'h9;
   // serial clock timing on the link clock
   localparam int SCL_HZ = 78000;
   localparam int LINK_PERIOD_NS = 160;
   localparam int QUARTER_CYC = 1000000000 / (LINK_PERIOD_NS * SCL_HZ * 4);
   localparam int BYTE_BITS = 8;
   // command with the byte captured at write time
   typedef struct packed {
      logic [3:0] cmd;
      logic [7:0] data;
   } eesm_cmd_s;
   // result handed back from the link side
   typedef struct packed {
      logic [7:0] data;
      logic rx_ack;
   } eesm_res_s;
   typedef enum {EESM_IDLE, EESM_START, EESM_STOP, EESM_BITS} eesm_state_e;
endpackage

// ### hw/eesm_master.sv
`timescale 1ns/1ps
module eesm_master (
   input wire logic clk, // system clock, 100 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic link_clk, // link-side clock
   input wire logic [7:0] sfr_addr, // special-function address
   input wire logic sfr_wr, // special-function write strobe
   input wire logic [7:0] sfr_wdata, // special-function write data
   output logic [7:0] sfr_rdata, // registered read data for sfr_addr
   input wire logic [15:0] cfg_addr, // configuration address
   input wire logic cfg_wr, // configuration write strobe
   input wire logic [7:0] cfg_wdata, // configuration write data
   output logic [7:0] cfg_rdata, // registered configuration read data
   output logic two_wire_pin_enable, // pin enable state
   output logic serial_done_interrupt, // one-cycle pulse when busy falls
   input wire logic gp_pin_four_i, // clock pin level
   output logic gp_pin_four_o, // clock pin drive value, always low
   output logic gp_pin_four_oe, // clock pin drive enable
   input wire logic gp_pin_five_i, // data pin level
   output logic gp_pin_five_o, // data pin drive value, always low
   output logic gp_pin_five_oe // data pin drive enable
);
   import eesm_pkg::*;

   // commands that move the bus
   function automatic logic eesm_bus_cmd(input logic [3:0] c);
      eesm_bus_cmd = (c == CMD_RX_ACK) || (c == CMD_TX) || (c == CMD_STOP) ||
                     (c == CMD_RX_LAST) || (c == CMD_START);
   endfunction

   // ---------------- system domain ----------------
   logic [7:0] byte_r;
   logic err_r, rx_ack_r, tx_ack_r, run_r, pin_en_r;
   eesm_cmd_s buf_r [2];
   logic wr_ptr_r, rd_ptr_r;
   logic [1:0] count_r;
   eesm_cmd_s hold_r;
   logic inflight_r, req_tgl_r, done_d_r, busy_q_r, irq_r;
   logic done_s1_r, done_s2_r, done_s3_r;
   logic [7:0] rdata_r, cfg_rdata_r;
   logic wr_cmd, wr_byte, push, pop, done_edge, busy;
   logic [3:0] code;
   eesm_res_s res_r;
   logic done_tgl_r;

   assign wr_cmd = sfr_wr && (sfr_addr == SFR_CMD_ADDR);
   assign wr_byte = sfr_wr && (sfr_addr == SFR_BYTE_ADDR);
   assign code = sfr_wdata[3:0];
   assign push = wr_cmd && eesm_bus_cmd(code) && (count_r != 2'h2);
   assign pop = (count_r != 2'h0) && !inflight_r;
   assign done_edge = done_s2_r ^ done_s3_r;
   assign busy = (count_r != 2'h0) || inflight_r;

   // pin enable in the configuration space
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_en_r <= 1'b0;
      end else if (cfg_wr && (cfg_addr == CFG_PIN_ADDR)) begin
         pin_en_r <= cfg_wdata[CFG_PIN_BIT];
      end
   end

   // configuration readback
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_rdata_r <= 8'h00;
      end else begin
         cfg_rdata_r <= (cfg_addr == CFG_PIN_ADDR) ? (8'h01 << CFG_PIN_BIT) & {8{pin_en_r}} : 8'h00;
      end
   end

   // two-entry command buffer, data captured with the command
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         count_r <= 2'h0;
         buf_r[0] <= '0;
         buf_r[1] <= '0;
      end else begin
         if (push) begin
            buf_r[wr_ptr_r] <= '{cmd: code, data: byte_r};
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         count_r <= count_r + {1'b0, push} - {1'b0, pop};
      end
   end

   // launch toward the link side and track completion
   always_ff @(posedge clk) begin
      if (rst) begin
         hold_r <= '0;
         req_tgl_r <= 1'b0;
         inflight_r <= 1'b0;
         done_d_r <= 1'b0;
      end else begin
         done_d_r <= done_edge;
         if (pop) begin
            hold_r <= buf_r[rd_ptr_r];
            req_tgl_r <= ~req_tgl_r;
            inflight_r <= 1'b1;
         end else if (done_d_r) begin
            inflight_r <= 1'b0;
         end
      end
   end

   // completion toggle synchroniser
   always_ff @(posedge clk) begin
      done_s1_r <= done_tgl_r;
      done_s2_r <= done_s1_r;
      done_s3_r <= done_s2_r;
   end

   // data register: software writes, received byte wins
   always_ff @(posedge clk) begin
      if (rst) begin
         byte_r <= BYTE_RESET;
      end else if (done_edge && (hold_r.cmd == CMD_RX_ACK || hold_r.cmd == CMD_RX_LAST)) begin
         byte_r <= res_r.data;
      end else if (wr_byte) begin
         byte_r <= sfr_wdata;
      end
   end

   // acknowledge status, updated a cycle before busy can fall
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_ack_r <= 1'b0;
         tx_ack_r <= 1'b0;
      end else if (done_edge) begin
         if (hold_r.cmd == CMD_TX) begin
            rx_ack_r <= res_r.rx_ack;
            tx_ack_r <= 1'b0;
         end else if (hold_r.cmd == CMD_RX_ACK) begin
            tx_ack_r <= 1'b1;
         end else if (hold_r.cmd == CMD_RX_LAST) begin
            tx_ack_r <= 1'b0;
         end
      end
   end

   // illegal command flag, cleared by the next legal code
   always_ff @(posedge clk) begin
      if (rst) begin
         err_r <= 1'b0;
      end else if (wr_cmd) begin
         err_r <= !(eesm_bus_cmd(code) || code == CMD_NOOP);
      end
   end

   // free-running clock request, stopped only by no-op
   always_ff @(posedge clk) begin
      if (rst) begin
         run_r <= 1'b0;
      end else if (wr_cmd && code == CMD_NOOP) begin
         run_r <= 1'b0;
      end else if (push) begin
         run_r <= 1'b1;
      end
   end

   // completion interrupt on busy falling
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_q_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         busy_q_r <= busy;
         irq_r <= busy_q_r && !busy;
      end
   end

   // registered read port
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= 8'h00;
      end else if (sfr_addr == SFR_BYTE_ADDR) begin
         rdata_r <= byte_r;
      end else if (sfr_addr == SFR_CMD_ADDR) begin
         rdata_r <= {err_r, busy, rx_ack_r, tx_ack_r, 4'h0};
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign sfr_rdata = rdata_r;
   assign cfg_rdata = cfg_rdata_r;
   assign two_wire_pin_enable = pin_en_r;
   assign serial_done_interrupt = irq_r;

   // ---------------- link domain ----------------
   logic lrst_s1_r, lrst_s2_r;
   logic lrst_req_r, lrst_ack_s1_r, lrst_ack_s2_r;
   logic req_s1_r, req_s2_r, req_s3_r;
   logic en_s1_r, en_s2_r, run_s1_r, run_s2_r;
   logic sda_s1_r, sda_s2_r;
   eesm_state_e state_r;
   logic [$clog2(QUARTER_CYC)-1:0] div_r;
   logic [1:0] quarter_r;
   logic [3:0] bit_r;
   logic [7:0] shift_r;
   logic go_r, scl_r, sda_r, ack_in_r;
   logic [3:0] lcmd_r;
   logic tick, is_tx, out_bit;
   logic scl_oe_r, sda_oe_r;

   assign tick = (div_r == ($clog2(QUARTER_CYC))'(QUARTER_CYC - 1));
   assign is_tx = (lcmd_r == CMD_TX);

   // link reset request, held until the link side has seen it
   always_ff @(posedge clk) begin
      lrst_ack_s1_r <= lrst_s2_r;
      lrst_ack_s2_r <= lrst_ack_s1_r;
      if (rst) begin
         lrst_req_r <= 1'b1;
      end else if (lrst_ack_s2_r) begin
         lrst_req_r <= 1'b0;
      end
   end

   // synchronisers into the link domain
   always_ff @(posedge link_clk) begin
      lrst_s1_r <= lrst_req_r;
      lrst_s2_r <= lrst_s1_r;
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      en_s1_r <= pin_en_r;
      en_s2_r <= en_s1_r;
      run_s1_r <= run_r;
      run_s2_r <= run_s1_r;
      sda_s1_r <= gp_pin_five_i;
      sda_s2_r <= sda_s1_r;
   end

   // quarter-bit divider
   always_ff @(posedge link_clk) begin
      if (lrst_s2_r || tick) begin
         div_r <= '0;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   // outgoing bit: msb first, ack slot released or driven
   always_comb begin
      if (bit_r == 4'(BYTE_BITS)) begin
         out_bit = is_tx ? 1'b1 : (lcmd_r != CMD_RX_ACK);
      end else begin
         out_bit = is_tx ? shift_r[7] : 1'b1;
      end
   end

   // bus sequencer
   always_ff @(posedge link_clk) begin
      if (lrst_s2_r) begin
         state_r <= EESM_IDLE;
         quarter_r <= 2'h0;
         bit_r <= 4'h0;
         shift_r <= 8'h00;
         go_r <= 1'b0;
         scl_r <= 1'b1;
         sda_r <= 1'b1;
         ack_in_r <= 1'b0;
         lcmd_r <= CMD_NOOP;
         done_tgl_r <= 1'b0;
      end else begin
         if (req_s2_r ^ req_s3_r) begin
            go_r <= 1'b1;
            lcmd_r <= hold_r.cmd; // stable while inflight
            shift_r <= hold_r.data;
         end
         if (tick) begin
            quarter_r <= quarter_r + 2'h1;
            case (state_r)
               EESM_IDLE: begin
                  if (go_r) begin
                     go_r <= 1'b0;
                     quarter_r <= 2'h0;
                     bit_r <= 4'h0;
                     if (lcmd_r == CMD_START) begin
                        state_r <= EESM_START;
                     end else if (lcmd_r == CMD_STOP) begin
                        state_r <= EESM_STOP;
                     end else begin
                        state_r <= EESM_BITS;
                     end
                  end else if (run_s2_r) begin
                     scl_r <= quarter_r[1];
                  end else begin
                     scl_r <= 1'b1;
                  end
               end
               EESM_START: begin
                  case (quarter_r)
                     2'h0: sda_r <= 1'b1;
                     2'h1: scl_r <= 1'b1;
                     2'h2: sda_r <= 1'b0;
                     2'h3: begin
                        scl_r <= 1'b0;
                        state_r <= EESM_IDLE;
                        done_tgl_r <= ~done_tgl_r;
                     end
                     default: ;
                  endcase
               end
               EESM_STOP: begin
                  case (quarter_r)
                     2'h0: scl_r <= 1'b0;
                     2'h1: sda_r <= 1'b0;
                     2'h2: scl_r <= 1'b1;
                     2'h3: begin
                        sda_r <= 1'b1;
                        state_r <= EESM_IDLE;
                        done_tgl_r <= ~done_tgl_r;
                     end
                     default: ;
                  endcase
               end
               EESM_BITS: begin
                  case (quarter_r)
                     2'h0: scl_r <= 1'b0;
                     2'h1: sda_r <= out_bit;
                     2'h2: scl_r <= 1'b1;
                     2'h3: begin
                        if (bit_r == 4'(BYTE_BITS)) begin
                           ack_in_r <= !sda_s2_r;
                           state_r <= EESM_IDLE;
                           done_tgl_r <= ~done_tgl_r;
                        end else begin
                           shift_r <= {shift_r[6:0], sda_s2_r};
                        end
                        bit_r <= bit_r + 4'h1;
                     end
                     default: ;
                  endcase
               end
               default: state_r <= EESM_IDLE;
            endcase
         end
      end
   end

   // open-drain pin drive, only while enabled, no stretching sensed
   always_ff @(posedge link_clk) begin
      if (lrst_s2_r) begin
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
      end else begin
         scl_oe_r <= en_s2_r && !scl_r;
         sda_oe_r <= en_s2_r && !sda_r;
      end
   end

   assign res_r = '{data: shift_r, rx_ack: ack_in_r};
   assign gp_pin_four_oe = scl_oe_r;
   assign gp_pin_five_oe = sda_oe_r;
   assign gp_pin_four_o = 1'b0;
   assign gp_pin_five_o = 1'b0;
endmodule

// ### dv/eesm_master_monitor.sv
`timescale 1ns/1ps
module eesm_master_monitor import eesm_pkg::*; (
   input wire logic clk, // system clock
   input wire logic rst, // reset
   input wire logic [7:0] sfr_addr, // register address
   input wire logic sfr_wr, // register write
   input wire logic [7:0] sfr_wdata, // register data
   input wire logic [7:0] sfr_rdata, // register read data
   input wire logic [15:0] cfg_addr, // config address
   input wire logic cfg_wr, // config write
   input wire logic [7:0] cfg_wdata, // config data
   input wire logic [7:0] cfg_rdata, // config read data
   input wire logic two_wire_pin_enable, // pin enable
   input wire logic serial_done_interrupt, // done pulse
   input wire logic gp_pin_four_o, // clock drive value
   input wire logic gp_pin_five_o, // data drive value
   input wire logic gp_pin_four_oe, // clock drive enable
   input wire logic gp_pin_five_oe // data drive enable
);
   logic [7:0] cfg_wdata_q;
   // codes that start bus work
   function automatic logic bus_code(input logic [3:0] c);
      return c == CMD_RX_ACK || c == CMD_TX || c == CMD_STOP || c == CMD_RX_LAST || c == CMD_START;
   endfunction
   // delayed config data
   always_ff @(posedge clk) begin
      cfg_wdata_q <= cfg_wdata;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_irq_one_pulse: assert property (serial_done_interrupt |=> !serial_done_interrupt)
      else $error("done pulse longer than one cycle");
   a_unmapped_reads_zero: assert property ($past(sfr_addr) != SFR_BYTE_ADDR && $past(sfr_addr) != SFR_CMD_ADDR
      |-> sfr_rdata == 8'h00)
      else $error("unmapped address read nonzero");
   a_status_low_zero: assert property ($past(sfr_addr) == SFR_CMD_ADDR |-> sfr_rdata[3:0] == 4'h0)
      else $error("status low bits nonzero");
   a_pin_enable_wr: assert property (cfg_wr && cfg_addr == CFG_PIN_ADDR
      |=> two_wire_pin_enable == cfg_wdata_q[CFG_PIN_BIT])
      else $error("pin enable not taken from config write");
   a_cfg_other_zero: assert property ($past(cfg_addr) != CFG_PIN_ADDR |-> cfg_rdata == 8'h00)
      else $error("config read of other address nonzero");
   a_pins_open_drain: assert property (!gp_pin_four_o && !gp_pin_five_o)
      else $error("pin drive value not low");
   a_pins_off_released: assert property ($fell(two_wire_pin_enable)
      |-> ##[1:64] (!gp_pin_four_oe && !gp_pin_five_oe))
      else $error("pins still driven after enable cleared");
   a_busy_after_cmd: assert property (sfr_wr && sfr_addr == SFR_CMD_ADDR && bus_code(sfr_wdata[3:0])
      ##1 sfr_addr == SFR_CMD_ADDR |=> sfr_rdata[ST_BUSY])
      else $error("busy not set after bus command");
   a_error_after_bad: assert property (sfr_wr && sfr_addr == SFR_CMD_ADDR && !bus_code(sfr_wdata[3:0])
      && sfr_wdata[3:0] != CMD_NOOP ##1 sfr_addr == SFR_CMD_ADDR |=> sfr_rdata[ST_ERROR])
      else $error("error bit not set by illegal code");
endmodule
bind eesm_master eesm_master_monitor u_mon (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
   .cfg_rdata(cfg_rdata), .two_wire_pin_enable(two_wire_pin_enable),
   .serial_done_interrupt(serial_done_interrupt), .gp_pin_four_o(gp_pin_four_o), .gp_pin_five_o(gp_pin_five_o),
   .gp_pin_four_oe(gp_pin_four_oe), .gp_pin_five_oe(gp_pin_five_oe));

// ### dv/eesm_eeprom_model.sv
`timescale 1ns/1ps
module eesm_eeprom_model (
   input wire logic scl, // clock wire level
   input wire logic sda, // data wire level
   input wire logic clr, // restarts bit count
   input wire logic rx_mode, // memory sends the byte
   input wire logic nak, // withhold ack on writes
   input wire logic [7:0] rd_byte, // byte sent on reads
   output logic sda_oe, // pulls data low, clock never touched
   output logic [7:0] wr_byte, // byte shifted in
   output logic got_ack, // master acknowledged
   output logic saw_start, // start seen
   output logic saw_stop, // stop seen
   output int edges // clock rises seen
);
   int cnt;
   initial begin
      sda_oe = 1'b0;
      wr_byte = 8'h00;
      got_ack = 1'b0;
      edges = 0;
      cnt = 9;
   end
   // fresh count per command
   always @(posedge clr) begin
      cnt = 0;
      saw_start = 1'b0;
      saw_stop = 1'b0;
   end
   // data edges while clock high
   always @(negedge sda) if (scl) saw_start = 1'b1;
   always @(posedge sda) if (scl) saw_stop = 1'b1;
   // memory moves data only while clock low
   always @(negedge scl) begin
      if (cnt < 8 && rx_mode) sda_oe = !rd_byte[7 - cnt];
      else if (cnt == 8 && !rx_mode && !nak) sda_oe = 1'b1;
      else sda_oe = 1'b0;
   end
   // sample at clock rise, msb first
   always @(posedge scl) begin
      edges = edges + 1;
      if (cnt < 8) wr_byte = {wr_byte[6:0], sda};
      if (cnt == 8) got_ack = !sda;
      cnt = cnt + 1;
   end
endmodule

// ### dv/eesm_master_tb.sv
`timescale 1ns/1ps
module eesm_master_tb;
   import eesm_pkg::*;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [15:0] cfg_addr = 16'h0000;
   logic cfg_wr = 1'b0;
   logic [7:0] cfg_wdata = 8'h00;
   logic [7:0] sfr_rdata, cfg_rdata, wr_byte, v, d;
   logic [7:0] rd_byte = 8'h00;
   logic [7:0] bad [10] = '{8'h01, 8'h04, 8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f};
   logic [7:0] exp_q [$];
   logic pin_en, irq, four_o, four_oe, five_o, five_oe, m_oe, got_ack, saw_start, saw_stop;
   logic clr = 1'b0;
   logic rx_mode = 1'b0;
   logic nak = 1'b0;
   wire scl = !four_oe;
   wire sda = !(five_oe || m_oe);
   int edges, e0, n, errors = 0, checked = 0, cycles = 0;
   int byte_cyc = QUARTER_CYC * 36 * LINK_PERIOD_NS / 10;
   initial forever #5 clk = !clk;
   initial begin
      #37;
      forever #80 link_clk = !link_clk;
   end
   eesm_master dut (.clk(clk), .rst(rst), .link_clk(link_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .two_wire_pin_enable(pin_en), .serial_done_interrupt(irq), .gp_pin_four_i(scl),
      .gp_pin_four_o(four_o), .gp_pin_four_oe(four_oe), .gp_pin_five_i(sda), .gp_pin_five_o(five_o),
      .gp_pin_five_oe(five_oe));
   eesm_eeprom_model mem (.scl(scl), .sda(sda), .clr(clr), .rx_mode(rx_mode), .nak(nak), .rd_byte(rd_byte),
      .sda_oe(m_oe), .wr_byte(wr_byte), .got_ack(got_ack), .saw_start(saw_start), .saw_stop(saw_stop),
      .edges(edges));
   task automatic stop_test();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= x;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] x);
      @(posedge clk);
      sfr_addr <= a;
      @(posedge clk);
      #1;
      x = sfr_rdata;
   endtask
   task automatic cwr(input logic [7:0] x);
      @(posedge clk);
      cfg_addr <= CFG_PIN_ADDR;
      cfg_wdata <= x;
      cfg_wr <= 1'b1;
      @(posedge clk);
      cfg_wr <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   // command, busy seen, wait for done, read status
   task automatic bus_cmd(input logic [3:0] c, output logic [7:0] st);
      @(posedge clk);
      clr <= 1'b1;
      wr(SFR_CMD_ADDR, {4'h0, c});
      clr <= 1'b0;
      rd(SFR_CMD_ADDR, st);
      check(st[ST_BUSY], 1'b1);
      n = 0;
      while (irq !== 1'b1 && n < 20000) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(n < 20000, 1'b1);
      rd(SFR_CMD_ADDR, st);
      check(st[ST_BUSY], 1'b0);
   endtask
   // cycle ceiling
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 90000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      void'($urandom(55));
      // reset held twelve cycles, the block stretches it for the link side
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(SFR_BYTE_ADDR, v);
      check(v, BYTE_RESET);
      rd(SFR_CMD_ADDR, v);
      check(v, 8'h00);
      wr(8'h55, 8'hff);
      rd(8'h55, v);
      check(v, 8'h00);
      check(scl, 1'b1);
      cwr(8'h10);
      check(cfg_rdata, 8'h10);
      check(pin_en, 1'b1);
      repeat (64) @(posedge clk);
      e0 = edges;
      foreach (bad[i]) begin
         wr(SFR_CMD_ADDR, bad[i]);
         rd(SFR_CMD_ADDR, v);
         check(v, 8'h80);
      end
      check(edges, e0);
      wr(SFR_CMD_ADDR, {4'h0, CMD_NOOP});
      rd(SFR_CMD_ADDR, v);
      check(v[ST_ERROR], 1'b0);
      bus_cmd(CMD_START, v);
      check(saw_start, 1'b1);
      for (int i = 0; i < 2; i++) begin
         d = 8'($urandom);
         exp_q.push_back(d);
         nak <= i[0];
         wr(SFR_BYTE_ADDR, d);
         bus_cmd(CMD_TX, v);
         check(wr_byte, exp_q.pop_front());
         check(v, i ? 8'h00 : 8'h20);
         check(n >= byte_cyc && n < byte_cyc + 400, 1'b1);
         wr(SFR_CMD_ADDR, {4'h0, CMD_NOOP});
      end
      rx_mode <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         d = 8'($urandom);
         rd_byte <= d;
         exp_q.push_back(d);
         bus_cmd(i ? CMD_RX_LAST : CMD_RX_ACK, v);
         check(v, i ? 8'h00 : 8'h10);
         check(got_ack, !i[0]);
         rd(SFR_BYTE_ADDR, d);
         check(d, exp_q.pop_front());
         wr(SFR_CMD_ADDR, {4'h0, CMD_NOOP});
      end
      rx_mode <= 1'b0;
      bus_cmd(CMD_STOP, v);
      // the final data rise reaches the pin a link cycle after done
      repeat (20) @(posedge clk);
      check(saw_stop, 1'b1);
      e0 = edges;
      repeat (3000) @(posedge clk);
      check(edges > e0, 1'b1);
      wr(SFR_CMD_ADDR, {4'h0, CMD_NOOP});
      repeat (400) @(posedge clk);
      e0 = edges;
      repeat (3000) @(posedge clk);
      check(edges, e0);
      check(scl, 1'b1);
      cwr(8'h00);
      check(pin_en, 1'b0);
      // pins left free for software once the enable is cleared
      repeat (80) @(posedge clk);
      check(four_oe || five_oe, 1'b0);
      stop_test();
   end
endmodule
